// *** uart_modem_pin_control.sv ***
`timescale 1ns/100ps
`default_nettype none
module uart_modem_pin_control #(
	parameter int SYNC_DEPTH = uart_pin_pkg::SYNC_STAGES
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Asynchronous active-high reset pin
	input  wire logic resetPin,
	// Control bits from the register file
	input  wire logic infrared_mode_bit,
	input  wire logic ir_rx_invert_bit,
	input  wire logic auto_req_flow_enable,
	input  wire logic req_send_control_bit,
	input  wire logic auto_clear_flow_enable,
	input  wire logic clear_flow_irq_enable,
	input  wire logic out_port2_bit,
	input  wire logic half_duplex_enable_bit,
	input  wire logic prescale_override_bit,
	input  wire logic prescale_override_valid,
	input  wire logic terminal_ready_bit,
	// Transmitter and receiver core side
	input  wire logic txSerialIn,
	input  wire logic txBusy,
	input  wire logic txLoad,
	input  wire logic rxFlowStop,
	input  wire logic coreIrq,
	output logic      rxToDecoder,
	output logic      txAllowed,
	output logic      clearFlowIrq,
	// Modem status readback
	output logic      clearToSendStatus,
	output logic      setReadyStatus,
	output logic      carrierDetectStatus,
	output logic      ringIndicatorStatus,
	// Clocking selects for the baud generator
	output logic [2:0] prescaleDivide,
	output logic [4:0] sampleRate,
	output logic      baudTick,
	// Serial and modem pins
	input  wire logic rx_line_b,
	output logic      tx_line_b,
	output logic      request_to_send_b_n,
	input  wire logic clear_to_send_b_n,
	output logic      terminal_ready_b_n,
	input  wire logic set_ready_b_n,
	input  wire logic carrier_detect_b_n,
	input  wire logic ring_indicator_b_n,
	output logic      out_port2_b_n,
	output logic      irq_b,
	output logic      irq_b_oe_n,
	// Strap pins
	input  wire logic half_duplex_strap_n,
	input  wire logic prescale_select,
	input  wire logic sample_rate_select
);
	// Elaboration check on synchroniser depth
	if (SYNC_DEPTH < 2) begin : gen_bad_depth
		$error("SYNC_DEPTH must be at least 2");
	end

	// Bit order of the bundle, highest first:
	//   6 receive line
	//   5 clear-to-send
	//   4 data-set-ready
	//   3 carrier detect
	//   2 ring indicator
	//   1 half-duplex strap
	//   0 sampling-rate strap
	// Half-duplex and sampling-rate straps are synchronised as well, since a board may move them live
	localparam int NSYNC = 7;
	// Bundled raw asynchronous inputs
	logic [NSYNC-1:0] rawIn;
	// Synchroniser chain, first stage read only by second
	logic [NSYNC-1:0] syncStage_r [SYNC_DEPTH];
	logic [NSYNC-1:0] syncStage_nxt [SYNC_DEPTH];
	logic [NSYNC-1:0] syncOut;
	// Reset pin synchroniser, separate so it resets only on resetn
	logic [SYNC_DEPTH-1:0] rstSync_r;
	logic [SYNC_DEPTH-1:0] rstSync_nxt;
	logic                  devReset;

	assign rawIn = {rx_line_b, clear_to_send_b_n, set_ready_b_n, carrier_detect_b_n,
		ring_indicator_b_n, half_duplex_strap_n, sample_rate_select};

	// Next values of the synchroniser chains
	always_comb begin
		syncStage_nxt[0] = rawIn;
		for (int i = 1; i < SYNC_DEPTH; i++) begin
			syncStage_nxt[i] = syncStage_r[i-1];
		end
		rstSync_nxt = {rstSync_r[SYNC_DEPTH-2:0], resetPin};
	end

	// Synchroniser registers; inputs idle at their inactive levels
	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int i = 0; i < SYNC_DEPTH; i++) begin
				syncStage_r[i] <= '1;
			end
			rstSync_r <= '0;
		end else begin
			syncStage_r <= syncStage_nxt;
			rstSync_r   <= rstSync_nxt;
		end
	end

	assign syncOut = syncStage_r[SYNC_DEPTH-1];
	// Device reset: either the system reset or the synchronised pin
	assign devReset = !resetn || rstSync_r[SYNC_DEPTH-1];

	// Named views of the synchronised inputs
	logic rxSync;
	logic ctsSync;
	logic hdStrapSync;
	logic rateSync;
	assign rxSync      = syncOut[6];
	assign ctsSync     = syncOut[5];
	assign hdStrapSync = syncOut[1];
	assign rateSync    = syncOut[0];

	// Receive path: invert only in infrared mode when asked
	always_comb begin
		if (devReset) begin
			rxToDecoder = infrared_mode_bit ? uart_pin_pkg::IDLE_LOW : uart_pin_pkg::IDLE_HIGH;
		end else if (infrared_mode_bit) begin
			rxToDecoder = rxSync ^ ir_rx_invert_bit;
		end else begin
			rxToDecoder = rxSync;
		end
	end

	// Clear-to-send gating of transmit and its interrupt
	assign txAllowed    = !(auto_clear_flow_enable && ctsSync);
	assign clearFlowIrq = auto_clear_flow_enable && clear_flow_irq_enable && ctsSync;

	// Status inputs; only clear-to-send also steers the transmitter
	assign clearToSendStatus   = !ctsSync;
	assign setReadyStatus      = !syncOut[4];
	assign carrierDetectStatus = !syncOut[3];
	assign ringIndicatorStatus = !syncOut[2];

	// Half-duplex select: strap wired OR with register bit
	logic halfDuplexOn;
	assign halfDuplexOn = !hdStrapSync || half_duplex_enable_bit;

	// Direction state machine for RS-485 mode
	// Receive: pin high, transceiver listens
	// Transmit: byte loaded, waiting for the shifter to report busy
	// Drain: shifter busy; hold transmit until the last stop bit is out
	// Limitation: the core must raise busy after a load, or the
	// machine waits in transmit until busy rises; a further load does not release it
	// Runs even when direction mode is off, so a late enable sees the truth
	uart_pin_pkg::dir_state_t dirState_r;
	uart_pin_pkg::dir_state_t dirState_nxt;

	// Next direction: transmit on load, receive after shifter empties
	always_comb begin
		dirState_nxt = dirState_r;
		case (dirState_r)
			uart_pin_pkg::DIR_RECEIVE: begin
				if (txLoad) begin
					dirState_nxt = uart_pin_pkg::DIR_TRANSMIT;
				end
			end
			uart_pin_pkg::DIR_TRANSMIT: begin
				if (txBusy) begin
					dirState_nxt = uart_pin_pkg::DIR_DRAIN;
				end
			end
			uart_pin_pkg::DIR_DRAIN: begin
				// Wait for final stop bit to leave the shifter
				if (!txBusy && !txLoad) begin
					dirState_nxt = uart_pin_pkg::DIR_RECEIVE;
				end
			end
			default: begin
				dirState_nxt = uart_pin_pkg::DIR_RECEIVE;
			end
		endcase
	end

	// Direction register
	always_ff @(posedge clk) begin
		if (devReset) begin
			dirState_r <= uart_pin_pkg::DIR_RECEIVE;
		end else begin
			dirState_r <= dirState_nxt;
		end
	end

	// Prescaler
	// Pin high selects divide by one, low divide by four
	// A valid software override wins over the pin; override bit set means four
	// The pin is taken through one flop only: it is a board strap, and a
	// glitch there costs at most one odd tick
	// Captured strap-level prescale choice, resampled every cycle after reset release
	logic prescaleSel_r;
	logic prescaleSel_nxt;
	logic [1:0] divCnt_r;
	logic [1:0] divCnt_nxt;
	logic       useDivOne;

	// Prescaler selection and divide-by-four counter
	always_comb begin
		prescaleSel_nxt = prescale_select;
		useDivOne = prescale_override_valid ? !prescale_override_bit : prescaleSel_r;
		if (useDivOne || divCnt_r == uart_pin_pkg::DIV_CNT_LAST) begin
			divCnt_nxt = uart_pin_pkg::DIV_CNT_RESET;
		end else begin
			divCnt_nxt = divCnt_r + 2'h1;
		end
	end

	// Prescaler registers
	always_ff @(posedge clk) begin
		if (devReset) begin
			prescaleSel_r <= 1'b1;
			divCnt_r      <= uart_pin_pkg::DIV_CNT_RESET;
		end else begin
			prescaleSel_r <= prescaleSel_nxt;
			divCnt_r      <= divCnt_nxt;
		end
	end

	// Pin outputs, all registered
	// Registering every pin costs one cycle of latency but keeps
	// combinational glitches off the board
	// Interrupt enable is active low: low drives the pin, high floats it
	// Port-2 pin and interrupt enable move together from the one bit
	logic txPin_nxt;
	logic rtsPin_nxt;
	logic dtrPin_nxt;
	logic op2Pin_nxt;
	logic irqPin_nxt;
	logic irqOe_nxt;
	logic tickNxt;
	logic [2:0] divNxt;
	logic [4:0] rateNxt;

	// Next pin values
	always_comb begin
		// Transmit pin takes the core serial stream in every mode
		txPin_nxt = txSerialIn;
		if (halfDuplexOn) begin
			rtsPin_nxt = (dirState_nxt == uart_pin_pkg::DIR_RECEIVE);
		end else if (auto_req_flow_enable) begin
			// Relies on software having set the control bit first
			rtsPin_nxt = !(req_send_control_bit && !rxFlowStop);
		end else begin
			rtsPin_nxt = !req_send_control_bit;
		end
		dtrPin_nxt = !terminal_ready_bit;
		op2Pin_nxt = !out_port2_bit;
		irqPin_nxt = out_port2_bit && coreIrq;
		irqOe_nxt  = !out_port2_bit;
		tickNxt    = useDivOne || divCnt_r == uart_pin_pkg::DIV_CNT_LAST;
		divNxt     = useDivOne ? 3'(uart_pin_pkg::PRESCALE_DIV_ONE) : 3'(uart_pin_pkg::PRESCALE_DIV_FOUR);
		rateNxt    = rateSync ? uart_pin_pkg::SAMPLE_X16 : uart_pin_pkg::SAMPLE_X8;
	end

	// Pin registers; reset drives every output to its default
	always_ff @(posedge clk) begin
		if (devReset) begin
			tx_line_b           <= uart_pin_pkg::IDLE_HIGH;
			request_to_send_b_n <= uart_pin_pkg::IDLE_HIGH;
			terminal_ready_b_n  <= uart_pin_pkg::IDLE_HIGH;
			out_port2_b_n       <= uart_pin_pkg::IDLE_HIGH;
			irq_b               <= uart_pin_pkg::IDLE_LOW;
			irq_b_oe_n          <= 1'b1;
			baudTick            <= 1'b0;
			prescaleDivide      <= 3'(uart_pin_pkg::PRESCALE_DIV_ONE);
			sampleRate          <= uart_pin_pkg::SAMPLE_X16;
		end else begin
			tx_line_b           <= txPin_nxt;
			request_to_send_b_n <= rtsPin_nxt;
			terminal_ready_b_n  <= dtrPin_nxt;
			out_port2_b_n       <= op2Pin_nxt;
			irq_b               <= irqPin_nxt;
			irq_b_oe_n          <= irqOe_nxt;
			baudTick            <= tickNxt;
			prescaleDivide      <= divNxt;
			sampleRate          <= rateNxt;
		end
	end
endmodule
`default_nettype wire

// *** uart_pin_pkg.sv ***
package uart_pin_pkg;
	// Prescaler ratios
	localparam int PRESCALE_DIV_ONE  = 1;
	localparam int PRESCALE_DIV_FOUR = 4;
	// Sampling oversample ratios
	localparam logic [4:0] SAMPLE_X16 = 5'h10;
	localparam logic [4:0] SAMPLE_X8  = 5'h08;
	// Minimum external reset pulse
	localparam int RESET_MIN_NS = 40;
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Synchroniser depth
	localparam int SYNC_STAGES = 2;
	// Pin idle levels
	localparam logic IDLE_HIGH = 1'b1;
	localparam logic IDLE_LOW  = 1'b0;
	// Counter reset and last values
	localparam logic [1:0] DIV_CNT_RESET = 2'h0;
	localparam logic [1:0] DIV_CNT_LAST  = 2'h3;
	// Direction FSM states
	typedef enum logic [1:0] {DIR_RECEIVE, DIR_TRANSMIT, DIR_DRAIN} dir_state_t;
endpackage

// *** uart_pin_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module uart_pin_props (
	// Clock and resets
	input wire logic       clk, resetn, resetPin,
	// Causes
	input wire logic       out_port2_bit, terminal_ready_bit, prescale_override_bit, prescale_override_valid,
	input wire logic       prescale_select, sample_rate_select, auto_clear_flow_enable, clear_to_send_b_n,
	input wire logic       ring_indicator_b_n, half_duplex_strap_n, txLoad,
	// Effects
	input wire logic       out_port2_b_n, irq_b_oe_n, terminal_ready_b_n, txAllowed, ringIndicatorStatus,
	input wire logic       request_to_send_b_n,
	input wire logic [2:0] prescaleDivide,
	input wire logic [4:0] sampleRate
);
	// Reset history, so the pin synchroniser tail is masked too
	logic [3:0] rstHist_r = 4'hF;
	always_ff @(posedge clk) rstHist_r <= {rstHist_r[2:0], !resetn || resetPin};
	wire quiet = !resetn || resetPin || (|rstHist_r);
	default clocking @(posedge clk); endclocking
	default disable iff (quiet);
	property p_op2Set; out_port2_bit |=> !out_port2_b_n && !irq_b_oe_n; endproperty
	a_op2Set: assert property (p_op2Set) else $error("port2 set, pin or irq wrong");
	property p_op2Clr; !out_port2_bit |=> out_port2_b_n && irq_b_oe_n; endproperty
	a_op2Clr: assert property (p_op2Clr) else $error("port2 clear, pin or irq wrong");
	property p_dtr; terminal_ready_b_n == !$past(terminal_ready_bit); endproperty
	a_dtr: assert property (p_dtr) else $error("terminal ready wrong");
	property p_rate16; sample_rate_select[*4] |-> sampleRate == uart_pin_pkg::SAMPLE_X16; endproperty
	a_rate16: assert property (p_rate16) else $error("rate not 16");
	property p_rate8; !sample_rate_select[*4] |-> sampleRate == uart_pin_pkg::SAMPLE_X8; endproperty
	a_rate8: assert property (p_rate8) else $error("rate not 8");
	property p_divOvr; prescale_override_valid && prescale_override_bit |=> prescaleDivide == 3'h4; endproperty
	a_divOvr: assert property (p_divOvr) else $error("override ignored");
	property p_divPin; (!prescale_override_valid && prescale_select)[*3] |-> prescaleDivide == 3'h1; endproperty
	a_divPin: assert property (p_divPin) else $error("divide not 1");
	property p_ctsGate; (auto_clear_flow_enable && clear_to_send_b_n)[*3] |-> !txAllowed; endproperty
	a_ctsGate: assert property (p_ctsGate) else $error("sending without clear");
	property p_ri; !ring_indicator_b_n[*3] |-> ringIndicatorStatus; endproperty
	a_ri: assert property (p_ri) else $error("ring status lost");
	property p_dir; !half_duplex_strap_n[*4] ##0 txLoad |=> !request_to_send_b_n; endproperty
	a_dir: assert property (p_dir) else $error("direction not transmit");
	// Main scenarios reached
	cover property (out_port2_bit ##1 !out_port2_bit);
	cover property (!half_duplex_strap_n && txLoad);
	cover property (prescale_override_valid && prescale_override_bit);
endmodule
bind uart_modem_pin_control uart_pin_props uart_pin_props_inst (.*);
`default_nettype wire

// *** modem_partner.sv ***
`timescale 1ns/100ps
`default_nettype none
module modem_partner (
	// Clock and UART pins
	input wire logic       clk,
	input wire logic       rtsN,
	// Bench commands: asserted CTS, DSR, CD, RI; late answer; data bit
	input wire logic [3:0] assertLines,
	input wire logic       slow,
	input wire logic       rxData,
	// Toward the UART
	output logic           rxLine,
	output logic     [3:0] statusN
);
	// Last command, for the slow answer
	logic [3:0] lateN_r;
	always_ff @(posedge clk) lateN_r <= ~assertLines;
	// Sender holds the line high unless allowed to send
	assign rxLine = rtsN ? 1'h1 : rxData;
	// Active-low status, prompt or one cycle late
	assign statusN = slow ? lateN_r : ~assertLines;
endmodule
`default_nettype wire

// *** test_uart_modem_pin_control.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module test_uart_modem_pin_control;
	// Clock, resets, bench state
	logic clk = 0, resetn = 0, resetPin = 0;
	int failures = 0, cmp_count = 0;
	logic [31:0] seed = 32'h38B1565A;
	// Design inputs
	logic infrared_mode_bit = 0, ir_rx_invert_bit = 0, auto_req_flow_enable = 0, req_send_control_bit = 0;
	logic auto_clear_flow_enable = 0, clear_flow_irq_enable = 0, out_port2_bit = 0, half_duplex_enable_bit = 0;
	logic prescale_override_bit = 0, prescale_override_valid = 0, terminal_ready_bit = 0, txSerialIn = 1;
	logic txBusy = 0, txLoad = 0, rxFlowStop = 0, coreIrq = 0, half_duplex_strap_n = 1, prescale_select = 1;
	logic sample_rate_select = 1, slow = 0, rxData = 1;
	logic [3:0] lines = 0;
	// Outputs and pins
	wire rxToDecoder, txAllowed, clearToSendStatus, setReadyStatus, carrierDetectStatus, ringIndicatorStatus;
	wire tx_line_b, request_to_send_b_n, terminal_ready_b_n, out_port2_b_n, irq_b, irq_b_oe_n, rx_line_b;
	wire clear_to_send_b_n, set_ready_b_n, carrier_detect_b_n, ring_indicator_b_n;
	wire clearFlowIrq, baudTick;
	wire [2:0] prescaleDivide;
	wire [4:0] sampleRate;
	uart_modem_pin_control uart_modem_pin_control_inst (.*);
	modem_partner modem_partner_inst (.clk, .rtsN(request_to_send_b_n), .assertLines(lines), .slow, .rxData,
		.rxLine(rx_line_b), .statusN({clear_to_send_b_n, set_ready_b_n, carrier_detect_b_n, ring_indicator_b_n}));
	always #5 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	// Expected divide: override bit set means four
	function automatic logic [2:0] expDiv(input logic v, b, s);
		return v ? (b ? 3'h4 : 3'h1) : (s ? 3'h1 : 3'h4);
	endfunction
	task automatic final_report();
		if (failures == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Random levels, held long enough to pass the synchronisers
	task automatic rand_run(input int n);
		repeat (n) begin
			seed = xs(seed);
			{infrared_mode_bit, ir_rx_invert_bit, auto_clear_flow_enable, clear_flow_irq_enable} = seed[3:0];
			{out_port2_bit, half_duplex_enable_bit, prescale_override_bit, prescale_override_valid} = seed[7:4];
			{terminal_ready_bit, txSerialIn, txBusy, rxFlowStop, coreIrq, half_duplex_strap_n} = seed[13:8];
			{sample_rate_select, slow, rxData, req_send_control_bit, lines} = seed[21:14];
			auto_req_flow_enable = seed[22] & req_send_control_bit;
			repeat (6) @(negedge clk);
			`CHK(out_port2_b_n, !out_port2_bit)
			`CHK(irq_b_oe_n, !out_port2_bit)
			if (out_port2_bit) `CHK(irq_b, coreIrq)
			`CHK(terminal_ready_b_n, !terminal_ready_bit)
			`CHK(prescaleDivide, expDiv(prescale_override_valid, prescale_override_bit, prescale_select))
			`CHK(sampleRate, sample_rate_select ? uart_pin_pkg::SAMPLE_X16 : uart_pin_pkg::SAMPLE_X8)
			`CHK(txAllowed, !(auto_clear_flow_enable && !lines[3]))
			`CHK(clearFlowIrq, auto_clear_flow_enable && clear_flow_irq_enable && !lines[3])
			`CHK(tx_line_b, txSerialIn)
			if (expDiv(prescale_override_valid, prescale_override_bit, prescale_select) == 3'h1) `CHK(baudTick, 1'h1)
			`CHK({clearToSendStatus, setReadyStatus, carrierDetectStatus, ringIndicatorStatus}, lines)
			`CHK(rxToDecoder, rx_line_b ^ (infrared_mode_bit & ir_rx_invert_bit))
		end
	endtask
	// Load, busy, drain: direction follows the shifter
	task automatic dir_run(input logic strap, hd);
		{half_duplex_strap_n, half_duplex_enable_bit, txBusy} = {strap, hd, 1'h0};
		repeat (6) @(negedge clk);
		`CHK(request_to_send_b_n, 1'h1)
		{txLoad, txBusy} = 2'h3;
		@(negedge clk);
		txLoad = 0;
		@(negedge clk);
		`CHK(request_to_send_b_n, 1'h0)
		repeat (20) @(negedge clk);
		`CHK(request_to_send_b_n, 1'h0)
		txBusy = 0;
		repeat (3) @(negedge clk);
		`CHK(request_to_send_b_n, 1'h1)
	endtask
	initial begin
		repeat (12) @(negedge clk);
		resetn = 1;
		rand_run(150);
		dir_run(0, 0);
		dir_run(1, 1);
		// Plain request-to-send under software control
		for (int v = 0; v < 2; v++) begin
			{half_duplex_strap_n, half_duplex_enable_bit, auto_req_flow_enable, rxFlowStop} = 4'h8;
			req_send_control_bit = v[0];
			repeat (4) @(negedge clk);
			`CHK(request_to_send_b_n, !v[0])
		end
		{prescale_select, prescale_override_valid, resetPin} = 3'h1;
		repeat (5) @(negedge clk);
		`CHK({tx_line_b, request_to_send_b_n, terminal_ready_b_n, out_port2_b_n, irq_b_oe_n}, 5'h1F)
		resetPin = 0;
		repeat (4) @(negedge clk);
		`CHK(prescaleDivide, expDiv(1'h0, 1'h0, prescale_select))
		rand_run(150);
		final_report();
	end
	// Hang guard
	initial begin
		#100000;
		failures++;
		final_report();
	end
endmodule
`default_nettype wire
